// file: iru_top.sv
// Interrupt sequencer, external pin flags and reset-cause register
`timescale 1ns/1ps
module iru_top
    import iru_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [2:0]        ext_pin,
    input  wire logic              pin_reset_n,
    input  wire logic              wdog_timeout,
    input  wire logic [7:0]        timer_flag_in,
    output logic      [7:0]        timer_flag_clr,
    input  wire logic              core_insn_boundary,
    input  wire logic              core_insn_done,
    input  wire logic              core_sleeping,
    input  wire logic              core_return,
    output logic                   entry_busy,
    output logic                   pc_push,
    output logic                   vector_valid,
    output logic      [12:0]       vector_addr,
    output logic                   return_busy,
    output logic                   return_done,
    output logic                   wdog_reset_pulse,
    output logic                   reset_delay_start,
    output logic                   global_enable
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_prev_q;
    logic       prst_s1_q;
    logic       prst_s2_q;

    // Two flops per pin; the previous value feeds edge detection only
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_q   <= 3'h7;
            pin_s2_q   <= 3'h7;
            pin_prev_q <= 3'h7;
            prst_s1_q  <= 1'h1;
            prst_s2_q  <= 1'h1;
        end else begin
            pin_s1_q   <= ext_pin;
            pin_s2_q   <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
            prst_s1_q  <= pin_reset_n;
            prst_s2_q  <= prst_s1_q;
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic [7:0] reg_idx;
    logic       apb_wr;
    logic       hit_cause;
    logic       hit_sense;
    logic       hit_tmask;
    logic       hit_eflag;
    logic       hit_emask;
    logic       hit_gctrl;
    logic       hit_any;

    // Zero-wait slave; unaligned or unknown words answer with an error
    assign reg_idx   = 8'(paddr >> 2);
    assign hit_cause = (reg_idx == IRU_IDX_RESET_CAUSE);
    assign hit_sense = (reg_idx == IRU_IDX_SENSE_CTRL);
    assign hit_tmask = (reg_idx == IRU_IDX_TIMER_MASK);
    assign hit_eflag = (reg_idx == IRU_IDX_EXT_FLAGS);
    assign hit_emask = (reg_idx == IRU_IDX_EXT_MASK);
    assign hit_gctrl = (reg_idx == IRU_IDX_GLOBAL_CTRL);
    assign hit_any   = (paddr[1:0] == 2'h0) && (hit_cause || hit_sense || hit_tmask
                       || hit_eflag || hit_emask || hit_gctrl);
    assign apb_wr    = psel && penable && pwrite && hit_any;
    assign pready    = 1'h1;
    assign pslverr   = psel && penable && !hit_any;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0] timer_irq_mask_q;
    logic [7:0] external_irq_mask_q;
    logic [4:0] sense_ctrl_q;

    // Plain software-written controls
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            timer_irq_mask_q    <= IRU_RST_ZERO;
            external_irq_mask_q <= IRU_RST_ZERO;
            sense_ctrl_q        <= 5'h00;
        end else begin
            if (apb_wr && hit_tmask) begin
                timer_irq_mask_q <= pwdata[7:0];
            end
            if (apb_wr && hit_emask) begin
                external_irq_mask_q <= pwdata[7:0] & IRU_EXT_MASK;
            end
            if (apb_wr && hit_sense) begin
                sense_ctrl_q <= pwdata[4:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Watchdog pulse and reset-cause register
    // ------------------------------------------------------------
    logic       wdog_q;
    logic       wdog_pulse_q;
    logic       delay_start_q;
    logic [7:0] reset_cause_status_q;
    logic [7:0] cause_d;

    // one cycle per time-out
    // Only the rising edge counts, so a held time-out still gives one pulse
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wdog_q        <= 1'h0;
            wdog_pulse_q  <= 1'h0;
            delay_start_q <= 1'h0;
        end else begin
            wdog_q        <= wdog_timeout;
            wdog_pulse_q  <= wdog_timeout && !wdog_q;
            delay_start_q <= wdog_pulse_q;
        end
    end

    // software zero clears, a source event sets and wins
    always_comb begin
        cause_d = reset_cause_status_q;
        if (apb_wr && hit_cause) begin
            cause_d = cause_d & pwdata[7:0];
        end
        if (wdog_pulse_q) begin
            cause_d[IRU_BIT_WDOG_SEEN] = 1'h1;
        end
        if (!prst_s2_q) begin
            cause_d[IRU_BIT_PIN_SEEN] = 1'h1;
        end
        cause_d = cause_d & IRU_CAUSE_MASK;
    end

    // Power-on reset is nrst: it leaves only the power-on flag set
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reset_cause_status_q <= IRU_RST_CAUSE;
        end else begin
            reset_cause_status_q <= cause_d;
        end
    end

    // ------------------------------------------------------------
    // External pin events
    // ------------------------------------------------------------
    logic [2:0] pin_fall;
    logic [2:0] pin_rise;
    logic [1:0] level_mode;
    logic [2:0] ext_event;

    // pin is sampled regardless of its direction
    assign pin_fall = pin_prev_q & ~pin_s2_q;
    assign pin_rise = ~pin_prev_q & pin_s2_q;

    // Sense selection for the two dual-mode pins and the edge-only pin
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sense
            logic [1:0] mode;
            assign mode           = sense_ctrl_q[2*gi+1:2*gi];
            assign level_mode[gi] = (mode == IRU_SENSE_LOW);
            assign ext_event[gi]  = (mode == IRU_SENSE_ANY  && (pin_fall[gi] || pin_rise[gi]))
                                 || (mode == IRU_SENSE_FALL && pin_fall[gi])
                                 || (mode == IRU_SENSE_RISE && pin_rise[gi]);
        end
    endgenerate
    // edge only, one bit picks the edge
    assign ext_event[2] = sense_ctrl_q[IRU_BIT_TWO_EDGE] ? pin_rise[2] : pin_fall[2];

    // ------------------------------------------------------------
    // Source requests and priority
    // ------------------------------------------------------------
    logic [7:0]          external_irq_flags_q;
    logic [IRU_NSRC-1:0] src_req;
    logic [2:0]          ext_en;
    logic [2:0]          ext_flag;
    logic                any_req;
    logic [3:0]          win_idx;

    // Slot 0 is pin zero, slot 1 pin one, slot 2 pin two
    assign ext_en   = {external_irq_mask_q[IRU_BIT_EXT2], external_irq_mask_q[IRU_BIT_EXT1],
                       external_irq_mask_q[IRU_BIT_EXT0]};
    assign ext_flag = {external_irq_flags_q[IRU_BIT_EXT2], external_irq_flags_q[IRU_BIT_EXT1],
                       external_irq_flags_q[IRU_BIT_EXT0]};

    generate
        for (gi = 0; gi < IRU_NSRC; gi++) begin : g_req
            if (gi < 2) begin : g_dual
                assign src_req[gi] = ext_en[gi] && (level_mode[gi] ? !pin_s2_q[gi] : ext_flag[gi]);
            end else if (gi == 2) begin : g_edge
                assign src_req[gi] = ext_en[gi] && ext_flag[gi];
            end else begin : g_timer
                assign src_req[gi] = timer_irq_mask_q[IRU_TBIT[gi]]
                                  && timer_flag_in[IRU_TBIT[gi]];
            end
        end
    endgenerate

    always_comb begin
        win_idx = 4'h0;
        for (int i = IRU_NSRC - 1; i >= 0; i--) begin
            if (src_req[i]) begin
                win_idx = 4'(i);
            end
        end
    end
    assign any_req = |src_req;

    // ------------------------------------------------------------
    // Entry and return sequencer
    // ------------------------------------------------------------
    iru_state_t state_q;
    logic [2:0] cnt_q;
    logic [3:0] serve_q;
    logic       gie_q;
    logic       hold_q;
    logic       accept;
    logic       push_end;
    logic       ret_end;

    // take only at a boundary, enabled, not held
    assign accept   = (state_q == IRU_ST_IDLE) && gie_q && any_req && core_insn_boundary
                      && !hold_q && !core_return;
    assign push_end = (state_q == IRU_ST_PUSH) && (cnt_q == 3'h1);
    assign ret_end  = (state_q == IRU_ST_RET) && (cnt_q == 3'h1);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= IRU_ST_IDLE;
            cnt_q   <= 3'h0;
            serve_q <= 4'h0;
        end else begin
            case (state_q)
                IRU_ST_IDLE: begin
                    if (core_return) begin
                        state_q <= IRU_ST_RET;
                        cnt_q   <= IRU_RET_CYC;
                    end else if (accept) begin
                        serve_q <= win_idx;
                        state_q <= core_sleeping ? IRU_ST_WAKE : IRU_ST_PUSH;
                        cnt_q   <= core_sleeping ? IRU_WAKE_CYC : IRU_ENTRY_CYC;
                    end
                end
                IRU_ST_WAKE: begin
                    cnt_q <= cnt_q - 3'h1;
                    if (cnt_q == 3'h1) begin
                        state_q <= IRU_ST_PUSH;
                        cnt_q   <= IRU_ENTRY_CYC;
                    end
                end
                IRU_ST_PUSH, IRU_ST_RET: begin
                    cnt_q <= cnt_q - 3'h1;
                    if (cnt_q == 3'h1) begin
                        state_q <= IRU_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= IRU_ST_IDLE;
                    cnt_q   <= 3'h0;
                end
            endcase
        end
    end

    // Global enable: software may set or clear it, except in the acceptance and return-end cycles
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gie_q  <= 1'h0;
            hold_q <= 1'h0;
        end else begin
            if (apb_wr && hit_gctrl) begin
                gie_q <= pwdata[IRU_BIT_GIE];
            end
            // acceptance wins over a software write
            if (accept) begin
                gie_q <= 1'h0;
            end
            if (ret_end) begin
                gie_q <= 1'h1;
            end
            // hold until one main-program instruction completes
            if (ret_end) begin
                hold_q <= 1'h1;
            end else if (core_insn_done) begin
                hold_q <= 1'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // External flags and served-flag clearing
    // ------------------------------------------------------------
    logic [2:0] ext_hw_clr;
    logic [2:0] ext_sw_clr;
    logic [2:0] ext_set;
    logic [2:0] ext_flag_d;

    // vectoring clears the flag of the served pin
    assign ext_hw_clr = {push_end && serve_q == 4'h2, push_end && serve_q == 4'h1,
                         push_end && serve_q == 4'h0};
    assign ext_sw_clr = (apb_wr && hit_eflag) ? {pwdata[IRU_BIT_EXT2], pwdata[IRU_BIT_EXT1],
                        pwdata[IRU_BIT_EXT0]} : 3'h0;
    // event sets the flag even when masked; level mode keeps none
    assign ext_set    = ext_event & {1'h1, ~level_mode};
    // An event in the clearing cycle is kept
    assign ext_flag_d = (ext_flag & ~(ext_hw_clr | ext_sw_clr)) | ext_set;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            external_irq_flags_q <= IRU_RST_ZERO;
        end else begin
            external_irq_flags_q <= {ext_flag_d[1], ext_flag_d[0], ext_flag_d[2], 5'h00};
        end
    end

    // ------------------------------------------------------------
    // Core-facing outputs
    // ------------------------------------------------------------
    logic        vec_valid_q;
    logic [12:0] vec_addr_q;
    logic        ret_done_q;
    logic [7:0]  tclr_q;

    // Vector and timer-flag clear issued together at entry end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            vec_valid_q <= 1'h0;
            vec_addr_q  <= 13'h0000;
            ret_done_q  <= 1'h0;
            tclr_q      <= 8'h00;
        end else begin
            vec_valid_q <= push_end;
            ret_done_q  <= ret_end;
            tclr_q      <= 8'h00;
            if (push_end) begin
                vec_addr_q <= IRU_VEC[serve_q];
                if (serve_q > 4'h2) begin
                    tclr_q <= 8'(8'h01 << IRU_TBIT[serve_q]);
                end
            end
        end
    end

    // status register is not saved here; handlers must do it
    assign entry_busy        = (state_q == IRU_ST_WAKE) || (state_q == IRU_ST_PUSH);
    assign pc_push           = (state_q == IRU_ST_PUSH);
    assign return_busy       = (state_q == IRU_ST_RET);
    assign vector_valid      = vec_valid_q;
    assign vector_addr       = vec_addr_q;
    assign return_done       = ret_done_q;
    assign timer_flag_clr    = tclr_q;
    assign wdog_reset_pulse  = wdog_pulse_q;
    assign reset_delay_start = delay_start_q;
    assign global_enable     = gie_q;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] rd_byte;

    // reserved and unmapped bits read zero
    assign rd_byte = hit_cause ? reset_cause_status_q
                   : hit_sense ? {3'h0, sense_ctrl_q}
                   : hit_tmask ? timer_irq_mask_q
                   : hit_eflag ? external_irq_flags_q
                   : hit_emask ? external_irq_mask_q
                   : hit_gctrl ? {gie_q, 3'h0, hold_q, return_busy, pc_push, entry_busy}
                   : 8'h00;
    assign prdata  = (psel && hit_any) ? {24'h000000, rd_byte} : 32'h00000000;

endmodule

// file: iru_pkg.sv
// Constants shared by the interrupt and reset-flag unit
package iru_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IRU_IDX_RESET_CAUSE = 8'h34;
    localparam logic [7:0] IRU_IDX_SENSE_CTRL  = 8'h35;
    localparam logic [7:0] IRU_IDX_TIMER_MASK  = 8'h39;
    localparam logic [7:0] IRU_IDX_EXT_FLAGS   = 8'h3A;
    localparam logic [7:0] IRU_IDX_EXT_MASK    = 8'h3B;
    localparam logic [7:0] IRU_IDX_GLOBAL_CTRL = 8'h3F;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int IRU_BIT_WDOG_SEEN = 3;
    localparam int IRU_BIT_PIN_SEEN  = 1;
    localparam int IRU_BIT_POR_SEEN  = 0;
    localparam int IRU_BIT_EXT1      = 7;
    localparam int IRU_BIT_EXT0      = 6;
    localparam int IRU_BIT_EXT2      = 5;
    localparam int IRU_BIT_GIE       = 7;
    localparam int IRU_BIT_TWO_EDGE  = 4;

    // Readable masks of the reset-cause and external registers
    localparam logic [7:0] IRU_CAUSE_MASK = 8'h0B;
    localparam logic [7:0] IRU_EXT_MASK   = 8'hE0;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] IRU_RST_CAUSE = 8'h01;
    localparam logic [7:0] IRU_RST_ZERO  = 8'h00;

    // ------------------------------------------------------------
    // Cycle counts of entry, wake-up and return
    // ------------------------------------------------------------
    localparam logic [2:0] IRU_ENTRY_CYC = 3'h4;
    localparam logic [2:0] IRU_WAKE_CYC  = 3'h4;
    localparam logic [2:0] IRU_RET_CYC   = 3'h4;

    // ------------------------------------------------------------
    // Sources in priority order (lowest vector first)
    // ------------------------------------------------------------
    localparam int IRU_NSRC = 11;
    localparam logic [12:0] IRU_VEC [IRU_NSRC] = '{
        13'h0002, 13'h0004, 13'h0006, 13'h0008, 13'h000A, 13'h000C,
        13'h000E, 13'h0010, 13'h0012, 13'h0014, 13'h0016};
    // Timer mask bit of sources 3..10 (sources 0..2 are external)
    localparam int IRU_TBIT [IRU_NSRC] = '{0, 0, 0, 2, 4, 3, 6, 5, 7, 0, 1};

    // Sense modes of external sources 0 and 1
    localparam logic [1:0] IRU_SENSE_LOW  = 2'h0;
    localparam logic [1:0] IRU_SENSE_ANY  = 2'h1;
    localparam logic [1:0] IRU_SENSE_FALL = 2'h2;
    localparam logic [1:0] IRU_SENSE_RISE = 2'h3;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        IRU_ST_IDLE = 4'h1,
        IRU_ST_WAKE = 4'h2,
        IRU_ST_PUSH = 4'h4,
        IRU_ST_RET  = 4'h8
    } iru_state_t;

endpackage

// file: iru_top_asserts.sv
// Port-level timing checks of the interrupt unit, bound into its top
`timescale 1ns/1ps
module iru_top_asserts (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        wdog_timeout,
    input wire logic        wdog_reset_pulse,
    input wire logic        reset_delay_start,
    input wire logic        entry_busy,
    input wire logic        pc_push,
    input wire logic        vector_valid,
    input wire logic [12:0] vector_addr,
    input wire logic [7:0]  timer_flag_clr,
    input wire logic        return_busy,
    input wire logic        return_done,
    input wire logic        global_enable
);
    // ------------------------------------------------
    // Watchdog, entry and return timing
    // ------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    AST_WDOG_PULSE: assert property (
        $rose(wdog_timeout) |=> wdog_reset_pulse ##1 !wdog_reset_pulse)
        else $error("watchdog reset pulse is not one cycle");
    AST_DELAY_START: assert property ($fell(wdog_reset_pulse) |-> reset_delay_start)
        else $error("delay start missing at pulse fall");
    AST_ACCEPT_GIE: assert property (
        $rose(entry_busy) |-> $past(global_enable) && !global_enable)
        else $error("accept without enable or enable not cleared");
    AST_PUSH_LEN: assert property (
        $rose(pc_push) |-> pc_push [*4] ##1 (!pc_push && vector_valid))
        else $error("push phase not four cycles before vector");
    // Sleeping core: four wake cycles come before the push
    AST_WAKE_LEN: assert property (
        $rose(entry_busy) && !pc_push |-> (entry_busy && !pc_push) [*4] ##1 pc_push)
        else $error("wake phase not four cycles");
    AST_RET_LEN: assert property (
        $rose(return_busy) |-> return_busy [*4] ##1 (return_done && global_enable))
        else $error("return not four cycles or enable not set");
    AST_RET_HOLD: assert property (return_done |=> !pc_push)
        else $error("entry right after return");
    AST_TIMER_CLR: assert property (
        vector_valid && vector_addr >= 13'h0008 |-> $onehot(timer_flag_clr))
        else $error("timer vector without single flag clear");
    cover property (vector_valid && vector_addr == 13'h0002);
    cover property (return_done);
    cover property (wdog_reset_pulse);
endmodule

bind iru_top iru_top_asserts u_asserts (.sys_clk, .nrst, .wdog_timeout, .wdog_reset_pulse,
    .reset_delay_start, .entry_busy, .pc_push, .vector_valid, .vector_addr, .timer_flag_clr,
    .return_busy, .return_done, .global_enable);

// file: iru_core_model.sv
// Behavioural core and timer flag source facing the interrupt unit
`timescale 1ns/1ps
module iru_core_model (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic [7:0] timer_set,
    input  wire logic       vector_valid,
    input  wire logic [7:0] timer_flag_clr,
    output logic            core_insn_boundary,
    output logic            core_insn_done,
    output logic            core_return,
    output logic [7:0]      timer_flag_in
);
    // ------------------------------------------------
    // Instruction stream, handler and timer flags
    // ------------------------------------------------
    logic [3:0] hcnt_q;
    // Every other cycle is mid-instruction, so entry must wait a boundary
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            {core_insn_boundary, core_insn_done, core_return} <= 3'h0;
            hcnt_q        <= 4'h0;
            timer_flag_in <= 8'h00;
        end else begin
            core_insn_boundary <= ~core_insn_boundary;
            core_insn_done     <= core_insn_boundary;
            hcnt_q      <= vector_valid ? 4'h9 : hcnt_q - {3'h0, hcnt_q != 4'h0};
            core_return <= (hcnt_q == 4'h1);
            timer_flag_in <= (timer_flag_in | timer_set) & ~timer_flag_clr;
        end
    end
endmodule

// file: tb_interrupt_and_reset_flag_unit.sv
// Self-checking bench for the interrupt and reset-flag unit
`timescale 1ns/1ps
module tb_interrupt_and_reset_flag_unit import iru_pkg::*; ;
    // ------------------------------------------------
    // Signals, design, core model and helpers
    // ------------------------------------------------
    logic        sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pin_reset_n = 1'b1, wdog_timeout = 1'b0, core_sleeping = 1'b0, hit;
    logic [7:0]  paddr = 8'h00, timer_set = 8'h00, ts, timer_flag_in, timer_flag_clr;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0]  ext_pin = 3'h7;
    logic        pready, pslverr, core_insn_boundary, core_insn_done, core_return, entry_busy;
    logic        pc_push, vector_valid, return_busy, return_done, wdog_reset_pulse;
    logic        reset_delay_start, global_enable;
    logic [12:0] vector_addr, ev, exp_q [$];
    logic [12:0] tvec [8] = '{13'h0014, 13'h0016, 13'h0008, 13'h000C, 13'h000A, 13'h0010,
                              13'h000E, 13'h0012};
    int          err_count = 0, num_checks = 0, seed = 58, v, b, n;
    iru_top u_dut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ext_pin, .pin_reset_n, .wdog_timeout, .timer_flag_in, .timer_flag_clr,
        .core_insn_boundary, .core_insn_done, .core_sleeping, .core_return, .entry_busy,
        .pc_push, .vector_valid, .vector_addr, .return_busy, .return_done, .wdog_reset_pulse,
        .reset_delay_start, .global_enable);
    iru_core_model u_core (.sys_clk, .nrst, .timer_set, .vector_valid, .timer_flag_clr,
        .core_insn_boundary, .core_insn_done, .core_return, .timer_flag_in);
    initial forever #5 sys_clk = ~sys_clk;
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Whole run needs a few hundred cycles; the 20000-cycle limit means a hang
    initial begin
        #200000;
        err_count++;
        final_report();
    end
    task automatic chk(input logic [31:0] ex, input logic [31:0] got, input string nm);
        num_checks++;
        if (got !== ex) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask
    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] wd);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {ix[5:0], 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdchk(input logic [7:0] ix, input logic [7:0] ex, input string nm);
        apb(1'b0, ix, 8'h00);
        chk({24'h000000, ex}, rd, nm);
    endtask
    // Wait until all expected vectors came, release sources, wait for return
    task automatic drain();
        for (n = 0; n < 3000 && exp_q.size() > 0; n++) @(posedge sys_clk);
        ext_pin       <= 3'h7;
        core_sleeping <= 1'b0;
        for (n = 0; n < 3000 && global_enable !== 1'b1; n++) @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
    endtask
    // Each vector is matched against the model order; unexpected ones fail
    always @(posedge sys_clk) begin
        if (vector_valid === 1'b1) begin
            ev = 13'h1FFF;
            if (exp_q.size() > 0)
                ev = exp_q.pop_front();
            chk({19'h0, ev}, {19'h0, vector_addr}, "vector");
            chk(32'h0, {31'h0, global_enable}, "gie at vector");
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        rdchk(IRU_IDX_RESET_CAUSE, 8'h01, "cause rst");
        rdchk(IRU_IDX_TIMER_MASK, 8'h00, "tmask rst");
        rdchk(IRU_IDX_EXT_FLAGS, 8'h00, "eflags rst");
        rdchk(8'h00, 8'h00, "unmapped");
        $display("registers done");
        pin_reset_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        pin_reset_n  <= 1'b1;
        wdog_timeout <= 1'b1;
        @(posedge sys_clk);
        wdog_timeout <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rdchk(IRU_IDX_RESET_CAUSE, 8'h0B, "cause set");
        apb(1'b1, IRU_IDX_RESET_CAUSE, 8'hFE);
        rdchk(IRU_IDX_RESET_CAUSE, 8'h0A, "por clear");
        apb(1'b1, IRU_IDX_RESET_CAUSE, 8'hF5);
        rdchk(IRU_IDX_RESET_CAUSE, 8'h00, "cause clear");
        $display("reset causes done");
        apb(1'b1, IRU_IDX_SENSE_CTRL, 8'h0A);
        apb(1'b1, IRU_IDX_GLOBAL_CTRL, 8'h80);
        ext_pin <= 3'h6;
        repeat (6) @(posedge sys_clk);
        rdchk(IRU_IDX_EXT_FLAGS, 8'h40, "masked flag");
        apb(1'b1, IRU_IDX_EXT_FLAGS, 8'h40);
        rdchk(IRU_IDX_EXT_FLAGS, 8'h00, "w1c");
        apb(1'b1, IRU_IDX_GLOBAL_CTRL, 8'h00);
        ts = 8'($random(seed));
        ext_pin   <= 3'h0;
        timer_set <= ts;
        @(posedge sys_clk);
        timer_set <= 8'h00;
        apb(1'b1, IRU_IDX_EXT_MASK, 8'hA0);
        apb(1'b1, IRU_IDX_TIMER_MASK, 8'hFF);
        rdchk(IRU_IDX_EXT_FLAGS, 8'hA0, "held flags");
        for (v = 2; v <= 22; v += 2) begin
            hit = (v == 4) || (v == 6);
            for (b = 0; b < 8; b++)
                hit = hit | (ts[b] && tvec[b] == 13'(v));
            if (hit)
                exp_q.push_back(13'(v));
        end
        apb(1'b1, IRU_IDX_GLOBAL_CTRL, 8'h80);
        drain();
        rdchk(IRU_IDX_EXT_FLAGS, 8'h00, "served flags");
        $display("priority done");
        apb(1'b1, IRU_IDX_GLOBAL_CTRL, 8'h00);
        apb(1'b1, IRU_IDX_SENSE_CTRL, 8'h08);
        ext_pin <= 3'h6;
        apb(1'b1, IRU_IDX_EXT_MASK, 8'h40);
        rdchk(IRU_IDX_EXT_FLAGS, 8'h00, "level flag");
        core_sleeping <= 1'b1;
        exp_q.push_back(13'h0002);
        apb(1'b1, IRU_IDX_GLOBAL_CTRL, 8'h80);
        drain();
        rdchk(IRU_IDX_GLOBAL_CTRL, 8'h80, "gie return");
        $display("level and sleep done");
        final_report();
    end
endmodule
